/* File: src/dre_engine.sv */
// Purpose: dma and interrupt address remapping engine
// Assumes: one table read outstanding; memory answers with mem_rvalid_i
// Notes:   two engine contexts share the walker, caches are per engine
// Contract
// R1: requester id indexes root and context tables
// R2: valid table found translates the address
// R3: no valid table raises translation fault
// R4: graphics engine and default engine kept separate
// R5: guest and host addresses 39 bits wide
// R6: low twelve address bits pass unchanged
// R7: single fault record, message interrupt per fault; code raises it only for faults that load the record, not while one is held
// R8: cache leaf and non-leaf table entries
// R9: never cache invalid table entries
// R10: drain pending transfers before invalidation completes
// R11: invalidate all, one domain, or one page
// R12: message window writes skip translation
// R13: faults go to video firmware, writes masked
// R14: faulting link reads return unsupported request
// R15: remap interrupt messages through interrupt table
// R16: queued invalidation port besides direct port
// R17: configured range passes through untranslated
// R18: four level walk, 48 bit guest width
// R19: large pages only on default engine
// R20: firmware disables large pages with graphics on
// R21: root, context and default context lookup
// R22: boot protection of default page table
// R23: held fault record not overwritten until cleared
`timescale 1ns/1ps
`include "dre_consts.svh"
module dre_engine #(
  parameter logic [15:0] GFX_BDF = 16'h0010
) (
  input  wire logic                  clock_i,
  input  wire logic                  rst_n_i,
  input  wire logic                  req_valid_i,
  input  wire dre_pkg::dre_req_t     req_i,
  output logic                       req_ready_o,
  output logic                       out_valid_o,
  output dre_pkg::dre_out_t          out_o,
  input  wire logic                  out_ready_i,
  input  wire logic                  pend_done_i,
  output logic                       mem_req_o,
  output logic [`DRE_HPA_W-1:0]      mem_addr_o,
  input  wire logic                  mem_rvalid_i,
  input  wire logic [63:0]           mem_rdata_i,
  input  wire logic [1:0]            trans_en_i,
  input  wire logic [`DRE_HPA_W-1:0] root_ptr_i,
  input  wire logic                  def_ctx_en_i,
  input  wire logic [`DRE_HPA_W-1:0] def_tbl_i,
  input  wire logic [`DRE_DOM_W-1:0] def_dom_i,
  input  wire logic                  large_page_en_i,
  input  wire logic [`DRE_GPA_W-1:0] pass_base_i,
  input  wire logic [`DRE_GPA_W-1:0] pass_limit_i,
  input  wire logic                  boot_prot_en_i,
  input  wire logic [`DRE_GPA_W-1:0] prot_base_i,
  input  wire logic [`DRE_GPA_W-1:0] prot_limit_i,
  input  wire logic [`DRE_HPA_W-1:0] video_fw_base_i,
  input  wire logic                  intr_remap_en_i,
  input  wire logic [`DRE_HPA_W-1:0] irt_base_i,
  input  wire logic                  inv_valid_i,
  input  wire dre_pkg::dre_inv_t     inv_i,
  output logic                       inv_ready_o,
  input  wire logic                  qinv_valid_i,
  input  wire dre_pkg::dre_inv_t     qinv_i,
  output logic                       qinv_ready_o,
  output logic                       inv_done_o,
  output logic                       fault_valid_o,
  output dre_pkg::dre_frec_t         fault_o,
  output logic                       fault_msi_o,
  input  wire logic                  fault_clear_i
);
  // ==========================================================
  // helpers
  function automatic logic in_rng(input logic [`DRE_GPA_W-1:0] a,
                                  input logic [`DRE_GPA_W-1:0] lo,
                                  input logic [`DRE_GPA_W-1:0] hi);
    in_rng = (a >= lo) && (a <= hi);
  endfunction : in_rng

  function automatic logic [`DRE_HPA_W-1:0] pte_addr(input logic [`DRE_PPN_W-1:0] tbl,
                                                    input logic [`DRE_AGAW-1:0] gpa,
                                                    input logic [1:0] lvl);
    logic [`DRE_AGAW-1:0] sh;
    sh = gpa >> (`DRE_PG_SH + `DRE_LVL_BITS * lvl);
    pte_addr = {tbl, sh[`DRE_LVL_BITS-1:0], `DRE_PTE_SH'h0};
  endfunction : pte_addr

  function automatic logic [`DRE_HPA_W-1:0] leaf_hpa(input logic [63:0] pte,
                                                    input logic [`DRE_AGAW-1:0] gpa,
                                                    input logic [1:0] lvl);
    logic [`DRE_HPA_W-1:0] m;
    m = ~({`DRE_HPA_W{1'b1}} << (`DRE_PG_SH + `DRE_LVL_BITS * lvl));
    leaf_hpa = (pte[`DRE_HPA_W-1:0] & ~m) | (gpa[`DRE_HPA_W-1:0] & m); // R6
  endfunction : leaf_hpa

  dre_pkg::dre_st_t s;
  dre_pkg::dre_st_t n;

  // ==========================================================
  // handshake and data outputs
  assign req_ready_o   = (s.st == dre_pkg::DRE_IDLE) && !inv_valid_i && !qinv_valid_i;
  assign inv_ready_o   = (s.st == dre_pkg::DRE_IDLE);
  assign qinv_ready_o  = (s.st == dre_pkg::DRE_IDLE) && !inv_valid_i; // R16
  assign out_valid_o   = s.ov;
  assign out_o         = s.out;
  assign mem_req_o     = s.mreq;
  assign mem_addr_o    = s.maddr;
  assign inv_done_o    = s.inv_done;
  assign fault_valid_o = s.fv;
  assign fault_o       = s.frec;
  assign fault_msi_o   = s.msi;

  // ==========================================================
  // next state
  always_comb
  begin
    logic                  flt;
    logic                  fin;
    logic [`DRE_HPA_W-1:0] fa;
    logic [`DRE_AGAW-1:0]  gpa;
    logic                  eng;
    logic                  hit;
    logic                  nhit;
    logic [`DRE_PPN_W-1:0] hppn;
    logic                  lg;
    logic                  lf;
    logic                  inc;
    logic                  dec;
    flt  = 1'b0;
    fin  = 1'b0;
    fa   = '0;
    hit  = 1'b0;
    nhit = 1'b0;
    hppn = '0;
    lf   = 1'b0;
    n    = s;
    n.msi      = 1'b0;
    n.inv_done = 1'b0;
    gpa  = {{(`DRE_AGAW-`DRE_GPA_W){1'b0}}, s.req.addr}; // R5 R18
    lg   = large_page_en_i && !s.eng; // R19
    eng  = (req_i.bdf == GFX_BDF); // R4
    // non-faulting transfers, translated or passed through, still in flight downstream
    inc = s.ov && out_ready_i && !s.out.fault;
    dec = pend_done_i && (s.pend != '0);
    n.pend = s.pend + {{(`DRE_PEND_W-1){1'b0}}, inc} - {{(`DRE_PEND_W-1){1'b0}}, dec};
    if (mem_rvalid_i)
    begin
      n.mreq = 1'b0;
    end
    unique case (s.st)
      dre_pkg::DRE_IDLE:
      begin
        if (inv_valid_i || qinv_valid_i)
        begin
          n.inv = inv_valid_i ? inv_i : qinv_i; // R16
          n.st  = dre_pkg::DRE_INV;
        end
        else if (req_valid_i)
        begin
          n.req = req_i;
          n.eng = eng;
          for (int i = 0; i < dre_pkg::TLB_N; i++)
          begin
            if (s.leaf[eng][i].v && s.leaf[eng][i].bdf == req_i.bdf &&
                s.leaf[eng][i].vpn == {{(`DRE_AGAW-`DRE_GPA_W){1'b0}},
                                       req_i.addr[`DRE_GPA_W-1:`DRE_PG_SH]})
            begin
              hit  = 1'b1;
              hppn = s.leaf[eng][i].ppn;
            end
          end
          nhit = s.nl[eng].v && s.nl[eng].bdf == req_i.bdf &&
                 s.nl[eng].tag == {{(`DRE_AGAW-`DRE_GPA_W){1'b0}},
                                   req_i.addr[`DRE_GPA_W-1:`DRE_NL_SH]};
          if (req_i.wr && req_i.addr[`DRE_MSI_LSB +: `DRE_MSI_W] == `DRE_MSI_HI)
          begin
            if (intr_remap_en_i)
            begin
              n.maddr = irt_base_i + ({{(`DRE_HPA_W-`DRE_IRH_W){1'b0}},
                        req_i.addr[`DRE_IRH_LSB +: `DRE_IRH_W]} << `DRE_ENT_SH); // R15
              n.mreq  = 1'b1;
              n.st    = dre_pkg::DRE_IRTE;
            end
            else
            begin
              fin = 1'b1; // R12
              fa  = req_i.addr;
            end
          end
          else if (!trans_en_i[eng])
          begin
            if (boot_prot_en_i && in_rng(req_i.addr, prot_base_i, prot_limit_i))
            begin
              flt = 1'b1; // R22
            end
            else
            begin
              fin = 1'b1;
              fa  = req_i.addr;
            end
          end
          else if (in_rng(req_i.addr, pass_base_i, pass_limit_i))
          begin
            fin = 1'b1; // R17
            fa  = req_i.addr;
          end
          else if (hit)
          begin
            fin = 1'b1; // R8
            fa  = {hppn, req_i.addr[`DRE_PG_SH-1:0]};
          end
          else if (nhit)
          begin
            n.tbl   = s.nl[eng].tbl; // R8
            n.dom   = s.nl[eng].dom;
            n.lvl   = `DRE_LVL_4K;
            n.maddr = pte_addr(s.nl[eng].tbl, {{(`DRE_AGAW-`DRE_GPA_W){1'b0}}, req_i.addr},
                               `DRE_LVL_4K);
            n.mreq  = 1'b1;
            n.st    = dre_pkg::DRE_WALK;
          end
          else
          begin
            n.maddr = {root_ptr_i[`DRE_HPA_W-1:`DRE_PG_SH], req_i.bdf[15:8],
                       `DRE_ENT_SH'h0}; // R1
            n.mreq  = 1'b1;
            n.st    = dre_pkg::DRE_ROOT;
          end
        end
      end
      dre_pkg::DRE_ROOT, dre_pkg::DRE_CTX:
      begin
        if (mem_rvalid_i)
        begin
          if (mem_rdata_i[`DRE_PRES] && s.st == dre_pkg::DRE_ROOT)
          begin
            n.maddr = {mem_rdata_i[`DRE_HPA_W-1:`DRE_PG_SH], s.req.bdf[7:0],
                       `DRE_ENT_SH'h0}; // R1
            n.mreq  = 1'b1;
            n.st    = dre_pkg::DRE_CTX;
          end
          else if (mem_rdata_i[`DRE_PRES] || def_ctx_en_i)
          begin
            // context entry, or the default context for requesters without one
            n.tbl = mem_rdata_i[`DRE_PRES] && s.st == dre_pkg::DRE_CTX ?
                    mem_rdata_i[`DRE_HPA_W-1:`DRE_PG_SH] :
                    def_tbl_i[`DRE_HPA_W-1:`DRE_PG_SH]; // R21
            n.dom = mem_rdata_i[`DRE_PRES] && s.st == dre_pkg::DRE_CTX ?
                    mem_rdata_i[`DRE_DOM_LSB +: `DRE_DOM_W] : def_dom_i;
            n.lvl   = `DRE_LVL_TOP; // R18
            n.maddr = pte_addr(n.tbl, gpa, `DRE_LVL_TOP);
            n.mreq  = 1'b1;
            n.st    = dre_pkg::DRE_WALK;
          end
          else
          begin
            flt = 1'b1; // R3
          end
        end
      end
      dre_pkg::DRE_WALK:
      begin
        if (mem_rvalid_i)
        begin
          lf = (s.lvl == `DRE_LVL_4K) || (lg && mem_rdata_i[`DRE_PTE_PS] &&
               (s.lvl == `DRE_LVL_2M || s.lvl == `DRE_LVL_1G)); // R19
          if (!mem_rdata_i[`DRE_PTE_R] && !mem_rdata_i[`DRE_PTE_W])
          begin
            flt = 1'b1; // R3 R9
          end
          else if (lf && s.req.wr && !mem_rdata_i[`DRE_PTE_W])
          begin
            flt = 1'b1;
          end
          else if (lf)
          begin
            fin = 1'b1; // R2
            fa  = leaf_hpa(mem_rdata_i, gpa, s.lvl);
            n.leaf[s.eng][s.rr[s.eng]] = '{v: 1'b1, bdf: s.req.bdf, dom: s.dom,
                                           vpn: gpa[`DRE_AGAW-1:`DRE_PG_SH],
                                           ppn: fa[`DRE_HPA_W-1:`DRE_PG_SH]}; // R8
            n.rr[s.eng] = s.rr[s.eng] + 1'b1;
          end
          else
          begin
            if (s.lvl == `DRE_LVL_2M)
            begin
              n.nl[s.eng] = '{v: 1'b1, bdf: s.req.bdf, dom: s.dom,
                              tag: gpa[`DRE_AGAW-1:`DRE_NL_SH],
                              tbl: mem_rdata_i[`DRE_HPA_W-1:`DRE_PG_SH]}; // R8
            end
            n.tbl   = mem_rdata_i[`DRE_HPA_W-1:`DRE_PG_SH];
            n.lvl   = s.lvl - 1'b1; // R18
            n.maddr = pte_addr(n.tbl, gpa, n.lvl);
            n.mreq  = 1'b1;
          end
        end
      end
      dre_pkg::DRE_IRTE:
      begin
        if (mem_rvalid_i)
        begin
          if (mem_rdata_i[`DRE_PRES])
          begin
            fin = 1'b1; // R15
            fa  = {s.req.addr[`DRE_GPA_W-1:`DRE_MSI_LSB],
                   mem_rdata_i[`DRE_IRD_LSB +: `DRE_IRD_W], s.req.addr[`DRE_PG_SH-1:0]};
          end
          else
          begin
            flt = 1'b1;
          end
        end
      end
      dre_pkg::DRE_OUT:
      begin
        if (out_ready_i)
        begin
          n.ov = 1'b0;
          n.st = dre_pkg::DRE_IDLE;
        end
      end
      dre_pkg::DRE_INV:
      begin
        if (s.pend == '0) // R10
        begin
          for (int e = 0; e < 2; e++)
          begin
            for (int i = 0; i < dre_pkg::TLB_N; i++)
            begin
              if (s.inv.scope == dre_pkg::DRE_INV_GLOBAL ||
                  (s.inv.scope == dre_pkg::DRE_INV_DOMAIN && s.leaf[e][i].dom == s.inv.dom) ||
                  (s.inv.scope == dre_pkg::DRE_INV_PAGE && s.leaf[e][i].vpn == s.inv.vpn))
              begin
                n.leaf[e][i].v = 1'b0; // R11
              end
            end
            if (s.inv.scope == dre_pkg::DRE_INV_GLOBAL ||
                (s.inv.scope == dre_pkg::DRE_INV_DOMAIN && s.nl[e].dom == s.inv.dom) ||
                (s.inv.scope == dre_pkg::DRE_INV_PAGE &&
                 s.nl[e].tag == s.inv.vpn[`DRE_VPN_W-1:`DRE_NL_SH-`DRE_PG_SH]))
            begin
              n.nl[e].v = 1'b0; // R11
            end
          end
          n.inv_done = 1'b1;
          n.st       = dre_pkg::DRE_IDLE;
        end
      end
      default:
      begin
        n.st = dre_pkg::DRE_IDLE;
      end
    endcase
    // forwarded result, normal or redirected
    if (fin || flt)
    begin
      n.out.addr  = flt ? video_fw_base_i : fa; // R13
      n.out.wr    = n.req.wr;
      n.out.be    = (flt && n.req.wr) ? 4'h0 : n.req.be; // R13
      n.out.fault = flt;
      n.out.unsup = flt && !n.req.wr && n.req.src != dre_pkg::DRE_SRC_INT; // R14
      n.ov        = 1'b1;
      n.st        = dre_pkg::DRE_OUT;
    end
    // fault record: a new fault wins over a clear in the same cycle
    if (fault_clear_i)
    begin
      n.fv = 1'b0;
    end
    if (flt && (!s.fv || fault_clear_i)) // R23
    begin
      n.fv   = 1'b1; // R7
      n.frec = '{bdf: n.req.bdf, addr: n.req.addr, wr: n.req.wr};
      n.msi  = 1'b1; // R7
    end
  end

  // ==========================================================
  // state register
  always_ff @(posedge clock_i)
  begin
    if (!rst_n_i)
    begin
      s    <= '0;
      s.st <= dre_pkg::DRE_IDLE;
    end
    else
    begin
      s <= n;
    end
  end

  // ==========================================================
  // checks
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rst_n_i);

  sequence msi_take;
    req_valid_i && req_ready_o && req_i.wr && !intr_remap_en_i &&
    req_i.addr[`DRE_MSI_LSB +: `DRE_MSI_W] == `DRE_MSI_HI;
  endsequence
  sequence out_same_addr;
    out_valid_o && !out_o.fault && out_o.addr == $past(req_i.addr);
  endsequence

  a_msi_bypass: assert property (msi_take |=> out_same_addr) // R12
    else $error("message write was not passed untranslated");
  a_fault_mask: assert property (out_valid_o && out_o.fault && out_o.wr |-> out_o.be == 4'h0) // R13
    else $error("faulting write kept byte enables");
  a_fault_unsup: assert property (out_valid_o && out_o.fault && !out_o.wr && // R14
                                  s.req.src != dre_pkg::DRE_SRC_INT |-> out_o.unsup)
    else $error("faulting link read lacks unsupported status");
  a_inv_drain: assert property ($rose(inv_done_o) |-> $past(s.pend) == '0) // R10
    else $error("invalidation finished with transfers pending");
  a_fault_hold: assert property (fault_valid_o && !fault_clear_i |=> // R23
                                 fault_valid_o && $stable(fault_o))
    else $error("held fault record changed");
  a_fault_msi: assert property ($rose(fault_valid_o) |-> fault_msi_o) // R7
    else $error("new fault record without message interrupt");
  a_page_offset: assert property (out_valid_o && !out_o.fault |-> // R6
                                  out_o.addr[`DRE_PG_SH-1:0] == s.req.addr[`DRE_PG_SH-1:0])
    else $error("page offset altered");
  a_no_bad_fill: assert property (s.st == dre_pkg::DRE_WALK && mem_rvalid_i && // R9
                                  !mem_rdata_i[`DRE_PTE_R] && !mem_rdata_i[`DRE_PTE_W]
                                  |=> s.leaf == $past(s.leaf) && s.nl == $past(s.nl))
    else $error("invalid table entry entered a cache");
  a_root_fault: assert property (s.st == dre_pkg::DRE_ROOT && mem_rvalid_i && // R3
                                 !mem_rdata_i[`DRE_PRES] && !def_ctx_en_i
                                 |=> out_valid_o && out_o.fault)
    else $error("missing root entry did not fault");
endmodule : dre_engine

/* File: src/dre_consts.svh */
// Purpose: constants of the address remapping engine
// Assumes: included by the package and the engine
// Notes:   widths, entry shifts and field positions
`ifndef DRE_CONSTS_SVH
`define DRE_CONSTS_SVH
// ==========================================================
// address widths
`define DRE_GPA_W    39
`define DRE_HPA_W    39
`define DRE_AGAW     48
`define DRE_PG_SH    12
`define DRE_PPN_W    27
`define DRE_VPN_W    36
`define DRE_NL_SH    21
`define DRE_NLT_W    27
`define DRE_LVL_BITS 9
`define DRE_LVL_TOP  2'h3
`define DRE_LVL_1G   2'h2
`define DRE_LVL_2M   2'h1
`define DRE_LVL_4K   2'h0
// ==========================================================
// table entry layout
`define DRE_ENT_SH   4
`define DRE_PTE_SH   3
`define DRE_PRES     0
`define DRE_PTE_R    0
`define DRE_PTE_W    1
`define DRE_PTE_PS   7
`define DRE_DOM_LSB  48
`define DRE_DOM_W    16
`define DRE_IRD_LSB  40
`define DRE_IRD_W    8
`define DRE_IRH_LSB  5
`define DRE_IRH_W    15
// ==========================================================
// message window and counters
`define DRE_MSI_LSB  20
`define DRE_MSI_W    12
`define DRE_MSI_HI   12'hFEE
`define DRE_PEND_W   4
`endif

/* File: src/dre_pkg.sv */
// Purpose: types of the address remapping engine
// Assumes: dre_consts.svh supplies the widths
// Notes:   all engine state lives in dre_st_t
`include "dre_consts.svh"
package dre_pkg;
  localparam int TLB_N = 4;
  typedef enum logic [6:0] {
    DRE_IDLE = 7'h01, DRE_ROOT = 7'h02, DRE_CTX = 7'h04, DRE_WALK = 7'h08,
    DRE_IRTE = 7'h10, DRE_OUT = 7'h20, DRE_INV = 7'h40
  } dre_state_t;
  typedef enum logic [1:0] {
    DRE_SRC_INT = 2'h0, DRE_SRC_GPL = 2'h1, DRE_SRC_CHL = 2'h2
  } dre_src_t;
  typedef enum logic [1:0] {
    DRE_INV_GLOBAL = 2'h0, DRE_INV_DOMAIN = 2'h1, DRE_INV_PAGE = 2'h2
  } dre_scope_t;
  typedef struct packed {
    logic [15:0]           bdf;
    logic [`DRE_GPA_W-1:0] addr;
    logic                  wr;
    logic [3:0]            be;
    dre_src_t              src;
  } dre_req_t;
  typedef struct packed {
    logic [`DRE_HPA_W-1:0] addr;
    logic                  wr;
    logic [3:0]            be;
    logic                  fault;
    logic                  unsup;
  } dre_out_t;
  typedef struct packed {
    dre_scope_t            scope;
    logic [`DRE_DOM_W-1:0] dom;
    logic [`DRE_VPN_W-1:0] vpn;
  } dre_inv_t;
  typedef struct packed {
    logic                  v;
    logic [15:0]           bdf;
    logic [`DRE_DOM_W-1:0] dom;
    logic [`DRE_VPN_W-1:0] vpn;
    logic [`DRE_PPN_W-1:0] ppn;
  } dre_leaf_t;
  typedef struct packed {
    logic                  v;
    logic [15:0]           bdf;
    logic [`DRE_DOM_W-1:0] dom;
    logic [`DRE_NLT_W-1:0] tag;
    logic [`DRE_PPN_W-1:0] tbl;
  } dre_nl_t;
  typedef struct packed {
    logic [15:0]           bdf;
    logic [`DRE_GPA_W-1:0] addr;
    logic                  wr;
  } dre_frec_t;
  typedef struct packed {
    dre_state_t                        st;
    dre_req_t                          req;
    logic                              eng;
    logic [1:0]                        lvl;
    logic [`DRE_PPN_W-1:0]             tbl;
    logic [`DRE_DOM_W-1:0]             dom;
    logic                              mreq;
    logic [`DRE_HPA_W-1:0]             maddr;
    logic                              ov;
    dre_out_t                          out;
    logic [`DRE_PEND_W-1:0]            pend;
    dre_inv_t                          inv;
    logic                              inv_done;
    dre_leaf_t [1:0][TLB_N-1:0]        leaf;
    dre_nl_t [1:0]                     nl;
    logic [1:0][$clog2(TLB_N)-1:0]     rr;
    logic                              fv;
    dre_frec_t                         frec;
    logic                              msi;
  } dre_st_t;
endpackage : dre_pkg

/* File: bench/dre_mem_model.sv */
// Purpose: table memory partner of the remapping engine
// Assumes: one table read outstanding at a time
// Notes:   unwritten entries read as zero, so they are not present
`timescale 1ns/1ps
module dre_mem_model (
  input  wire logic        clock_i,
  input  wire logic        mem_req_i,
  input  wire logic [38:0] mem_addr_i,
  input  wire logic [3:0]  delay_i,
  output logic             mem_rvalid_o,
  output logic [63:0]      mem_rdata_o
);
  logic [63:0] mem [logic [38:0]];
  logic [3:0]  wait_cnt = 4'h0;
  // ==========================================================
  // answer after delay_i cycles; data scrambles outside the answer
  initial
  begin
    mem_rvalid_o = 1'b0;
    mem_rdata_o  = 64'h0;
  end
  always @(posedge clock_i)
  begin
    mem_rvalid_o <= 1'b0;
    mem_rdata_o  <= ~mem_rdata_o;
    wait_cnt     <= 4'h0;
    if (mem_req_i && !mem_rvalid_o && wait_cnt < delay_i)
      wait_cnt <= wait_cnt + 4'h1;
    else if (mem_req_i && !mem_rvalid_o)
    begin
      mem_rvalid_o <= 1'b1;
      mem_rdata_o  <= mem.exists(mem_addr_i) ? mem[mem_addr_i] : 64'h0;
    end
  end
endmodule : dre_mem_model

/* File: bench/tb_dre_engine.sv */
// Purpose: self-checking bench of the remapping engine
// Assumes: default engine except one graphics request, tables held by dre_mem_model
// Notes:   inputs change on the falling edge
`timescale 1ns/1ps
module tb_dre_engine;
  logic                clock_i, rst_n_i, req_valid_i, out_ready_i, pend_done_i;
  logic                inv_valid_i, qinv_valid_i, fault_clear_i, req_ready_o, out_valid_o;
  logic                inv_ready_o, qinv_ready_o, inv_done_o, fault_valid_o, fault_msi_o;
  logic                mem_req_o, mem_rvalid_i, mem_seen, done_seen;
  logic [1:0]          trans_en_i;
  logic [3:0]          delay, cfg;
  logic [38:0]         mem_addr_o, tbl;
  logic [63:0]         mem_rdata_i;
  dre_pkg::dre_req_t   req_i;
  dre_pkg::dre_out_t   out_o, res;
  dre_pkg::dre_inv_t   inv_i;
  dre_pkg::dre_frec_t  fault_o;
  int                  err_total, comparisons, msi_cnt;
  localparam logic [38:0] FW = 39'h0000C0000;
  // ==========================================================
  // instances
  dre_engine dre_engine_inst (.clock_i(clock_i), .rst_n_i(rst_n_i), .req_valid_i(req_valid_i),
    .req_i(req_i), .req_ready_o(req_ready_o), .out_valid_o(out_valid_o), .out_o(out_o),
    .out_ready_i(out_ready_i), .pend_done_i(pend_done_i), .mem_req_o(mem_req_o),
    .mem_addr_o(mem_addr_o), .mem_rvalid_i(mem_rvalid_i), .mem_rdata_i(mem_rdata_i),
    .trans_en_i(trans_en_i), .root_ptr_i(39'h1000), .def_ctx_en_i(cfg[0]),
    .def_tbl_i(tbl), .def_dom_i(16'h0), .large_page_en_i(cfg[1]),
    .pass_base_i(39'h1000000000), .pass_limit_i(39'h100000FFFF),
    .boot_prot_en_i(cfg[2]), .prot_base_i(tbl), .prot_limit_i(tbl),
    .video_fw_base_i(FW), .intr_remap_en_i(cfg[3]), .irt_base_i(tbl),
    .inv_valid_i(inv_valid_i), .inv_i(inv_i), .inv_ready_o(inv_ready_o),
    .qinv_valid_i(qinv_valid_i), .qinv_i(inv_i), .qinv_ready_o(qinv_ready_o),
    .inv_done_o(inv_done_o), .fault_valid_o(fault_valid_o), .fault_o(fault_o),
    .fault_msi_o(fault_msi_o), .fault_clear_i(fault_clear_i));
  dre_mem_model dre_mem_model_inst (.clock_i(clock_i), .mem_req_i(mem_req_o),
    .mem_addr_i(mem_addr_o), .delay_i(delay), .mem_rvalid_o(mem_rvalid_i),
    .mem_rdata_o(mem_rdata_i));
  // ==========================================================
  // clock, watchdog and event monitors
  initial
  begin
    clock_i = 1'b0;
    forever #20 clock_i = ~clock_i;
  end
  initial
  begin
    #800000;
    err_total++;
    wrap_up();
  end
  always @(posedge clock_i)
  begin
    if (mem_req_o) mem_seen = 1'b1;
    if (inv_done_o) done_seen = 1'b1;
    if (fault_msi_o) msi_cnt++;
  end
  // ==========================================================
  // shared tasks
  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      err_total++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic run_req(input logic [15:0] bdf, input logic [38:0] a, input logic wr,
                         input dre_pkg::dre_src_t src = dre_pkg::DRE_SRC_INT);
    mem_seen = 1'b0;
    req_i = '{bdf: bdf, addr: a, wr: wr, be: 4'hF, src: src};
    req_valid_i = 1'b1;
    while (!req_ready_o) @(negedge clock_i);
    @(negedge clock_i);
    req_valid_i = 1'b0;
    while (!out_valid_o) @(negedge clock_i);
    res = out_o;
    out_ready_i = 1'b1;
    @(negedge clock_i);
    out_ready_i = 1'b0;
  endtask : run_req
  task automatic inv_op(input logic q, input dre_pkg::dre_scope_t s, input int pulses);
    inv_i = '{scope: s, dom: 16'h0005, vpn: 36'h203};
    qinv_valid_i = q;
    inv_valid_i = !q;
    while (!(q ? qinv_ready_o : inv_ready_o)) @(negedge clock_i);
    @(negedge clock_i);
    {qinv_valid_i, inv_valid_i} = 2'b00;
    done_seen = 1'b0;
    repeat (6) @(negedge clock_i);
    chk(done_seen, 0);
    repeat (pulses)
    begin
      pend_done_i = 1'b1;
      @(negedge clock_i);
      pend_done_i = 1'b0;
      @(negedge clock_i);
    end
    repeat (4) @(negedge clock_i);
    chk(done_seen, 1);
  endtask : inv_op
  task automatic wrap_up;
    $display("comparisons=%0d err_total=%0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : wrap_up
  // ==========================================================
  // main sequence
  initial
  begin
    {rst_n_i, req_valid_i, out_ready_i, pend_done_i, inv_valid_i} = 5'h00;
    {qinv_valid_i, fault_clear_i} = 2'h0;
    {err_total, comparisons, msi_cnt} = '0;
    {trans_en_i, delay, cfg, tbl, req_i, inv_i} = '0;
    dre_mem_model_inst.mem[39'h1000] = 64'h2001;
    dre_mem_model_inst.mem[39'h2080] = 64'h0005000000003001;
    dre_mem_model_inst.mem[39'h3000] = 64'h4003;
    dre_mem_model_inst.mem[39'h4000] = 64'h5003;
    dre_mem_model_inst.mem[39'h5008] = 64'h6003;
    dre_mem_model_inst.mem[39'h6018] = 64'h7A003;
    dre_mem_model_inst.mem[39'h5010] = 64'hA00083;
    dre_mem_model_inst.mem[39'h8010] = 64'h00002A0000000001;
    repeat (10) @(negedge clock_i);
    {rst_n_i, trans_en_i, delay} = 7'h73;
    run_req(16'h0008, 39'h203ABC, 1'b0);
    chk(res.addr, 39'h7AABC);
    chk(mem_seen, 1);
    delay = 4'h0;
    run_req(16'h0008, 39'h203004, 1'b1);
    chk({res.addr, res.be}, {39'h7A004, 4'hF});
    chk(mem_seen, 0);
    run_req(16'h0100, 39'h5000, 1'b0, dre_pkg::DRE_SRC_CHL);
    chk({res.addr, res.fault, res.unsup}, {FW, 2'b11});
    chk({fault_valid_o, fault_o.bdf, msi_cnt[1:0]}, {17'h10100, 2'h1});
    run_req(16'h0008, 39'h204000, 1'b1);
    chk({res.addr, res.be, res.unsup}, {FW, 4'h0, 1'b0});
    chk({fault_o.bdf, msi_cnt[1:0]}, {16'h0100, 2'h1});
    run_req(16'h0008, 39'h204000, 1'b1);
    chk({res.fault, mem_seen}, 2'b11);
    fault_clear_i = 1'b1;
    @(negedge clock_i);
    fault_clear_i = 1'b0;
    chk(fault_valid_o, 0);
    run_req(16'h0008, 39'h00FEE00010, 1'b1);
    chk({res.addr, res.fault}, {39'h00FEE00010, 1'b0});
    run_req(16'h0008, 39'h1000001234, 1'b0, dre_pkg::DRE_SRC_GPL);
    chk({res.addr, mem_seen}, {39'h1000001234, 1'b0});
    inv_op(1'b1, dre_pkg::DRE_INV_GLOBAL, 4);
    run_req(16'h0008, 39'h203ABC, 1'b0);
    chk({res.addr, mem_seen}, {39'h7AABC, 1'b1});
    inv_op(1'b0, dre_pkg::DRE_INV_PAGE, 1);
    run_req(16'h0008, 39'h203ABC, 1'b0);
    chk(mem_seen, 1);
    inv_op(1'b0, dre_pkg::DRE_INV_DOMAIN, 1);
    run_req(16'h0008, 39'h203ABC, 1'b0);
    chk(mem_seen, 1);
    {cfg, tbl} = {4'h1, 39'h3000};
    run_req(16'h0200, 39'h203ABC, 1'b0);
    chk({res.addr, res.fault}, {39'h7AABC, 1'b0});
    {cfg, tbl} = {4'h8, 39'h8000};
    run_req(16'h0008, 39'h00FEE00020, 1'b1);
    chk(res.addr, 39'h00FEE2A020);
    {trans_en_i, cfg} = 6'h04;
    run_req(16'h0008, 39'h8000, 1'b1);
    chk({res.addr, res.be, fault_o.addr}, {FW, 4'h0, 39'h8000});
    {trans_en_i, cfg} = 6'h12;
    run_req(16'h0010, 39'h203ABC, 1'b0);
    chk({res.addr, mem_seen}, {39'h203ABC, 1'b0});
    run_req(16'h0008, 39'h412345, 1'b0);
    chk(res.addr, 39'hA12345);
    wrap_up();
  end
endmodule : tb_dre_engine
